// file: design/alarm_bearer_consts.svh
/*
 * Constants for the backward alarm and bearer select block: encodings, field
 * widths and reset values. Assumes inclusion by bare name from design files.
 */
`ifndef ALARM_BEARER_CONSTS_SVH
`define ALARM_BEARER_CONSTS_SVH

`define ALARM_CHANNELS 4
`define ALARM_OK 1'b1
`define ALARM_FAIL 1'b0
`define MAP_SEL_W 3
`define MAP_ALL_EXTERNAL 3'h1
`define MAP_FIRST_INT_REST_EXT 3'h2
`define MAP_FIRST_INT_REST_OK 3'h3
`define MAP_ALL_INTERNAL 3'h4
`define CLK_SEL_W 2
`define CLK_SATELLITE 2'h0
`define CLK_TRANSMIT 2'h1
`define CLK_INTERNAL 2'h2
`define CLK_STATION 2'h3
`define TRACK_W 32
`define LOCAL_W 16
`define TS_W 32
`define RATE_N_W 6
`define RATE_N_MIN 6'h02
`define RATE_N_MAX 6'h20
`define RATE_N_RESET 6'h02
`define TS_RESET 32'h00000000
`define TRACK_RESET 32'h00000000
`define LOCAL_RESET 16'h0000

`endif

// file: design/alarm_bearer_pkg.sv
/*
 * Types for the backward alarm and bearer select block.
 * Assumes the constants header is compiled alongside.
 */
package alarm_bearer_pkg;
    typedef enum logic [1:0] {
        BEARER_LOOPED = 2'b00,
        BEARER_BACKUP = 2'b01,
        BEARER_GENERATED = 2'b10
    } bearer_state_t;
endpackage

// file: design/alarm_bearer_select.sv
/*
 * Top of the backward alarm and bearer select block. Holds the receive
 * configuration that can follow transmit, the insert mux bearer routing with
 * backup failover, partial insert gating, and instantiates the alarm mapper.
 * Assumes the alarm pins and the bearer clock-loss and AIS flags arrive from
 * other clocks and are synchronised here; configuration inputs are levels or
 * single-cycle write strobes from the control processor on mclk.
 * Limitations: backup routing has no hysteresis, so a bearer that flaps makes
 * the routing flap with it, three edges behind the flag; debounce upstream.
 * Partial insert needs drop/insert active, and a rate multiple outside the
 * accepted range is flagged and leaves the last good multiple in force.
 * The count of inserted timeslots is not checked against the selection here.
 */
`timescale 1ns/100ps
`include "alarm_bearer_consts.svh"
module alarm_bearer_select
    import alarm_bearer_pkg::*;
#(
    parameter int CHANNELS = `ALARM_CHANNELS,
    parameter int TRACK_W = `TRACK_W,
    parameter int LOCAL_W = `LOCAL_W,
    parameter int TS_W = `TS_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Backward alarms
    input wire logic [`MAP_SEL_W-1:0] map_sel,
    input wire logic [CHANNELS-1:0] ext_alarm_n,
    input wire logic rx_fail,
    output logic [CHANNELS-1:0] alarm_ok,
    // Receive follows transmit
    input wire logic follow_tx,
    input wire logic [TRACK_W-1:0] tx_tracked_cfg,
    input wire logic [TRACK_W-1:0] rx_tracked_wr,
    input wire logic rx_tracked_we,
    input wire logic drop_insert,
    input wire logic [TS_W-1:0] rx_insert_ts_wr,
    input wire logic rx_insert_ts_we,
    input wire logic [LOCAL_W-1:0] rx_local_wr,
    input wire logic rx_local_we,
    output logic [TRACK_W-1:0] rx_tracked_cfg,
    output logic [TS_W-1:0] rx_insert_ts,
    output logic [LOCAL_W-1:0] rx_local_cfg,
    // Bearer routing
    input wire logic generate_mode,
    input wire logic bearer_clk_lost,
    input wire logic bearer_ais,
    input wire logic [`CLK_SEL_W-1:0] gen_clk_sel,
    input wire logic [`CLK_SEL_W-1:0] backup_clk_sel,
    input wire logic fmt_multiframe,
    input wire logic fmt_crc,
    input wire logic cas_mode,
    output logic [1:0] bearer_state,
    output logic use_generated,
    output logic [`CLK_SEL_W-1:0] bearer_clk_sel,
    output logic gen_multiframe,
    output logic gen_crc,
    output logic gen_ts16_mf,
    // Partial insert
    input wire logic partial_req,
    input wire logic [`RATE_N_W-1:0] sat_rate_n,
    input wire logic [TS_W-1:0] sat_ts_select,
    input wire logic [TS_W-1:0] rx_slot_strobe,
    output logic partial_active,
    output logic [`RATE_N_W-1:0] total_rate_n,
    output logic rate_n_error,
    output logic [TS_W-1:0] insert_slot_en
);
    // Routing state and receive configuration
    bearer_state_t state_q;
    bearer_state_t state_d;
    logic [TRACK_W-1:0] tracked_q;
    logic [TRACK_W-1:0] tracked_d;
    logic [TS_W-1:0] ts_q;
    logic [TS_W-1:0] ts_d;
    logic [LOCAL_W-1:0] local_q;
    logic [LOCAL_W-1:0] local_d;
    // Line status synchronisers, first and second stage
    logic clk_meta_q;
    logic clk_sync_q;
    logic ais_meta_q;
    logic ais_sync_q;
    // Generator controls
    logic use_gen_q;
    logic use_gen_d;
    logic [`CLK_SEL_W-1:0] clk_sel_q;
    logic [`CLK_SEL_W-1:0] clk_sel_d;
    logic mf_q;
    logic mf_d;
    logic crc_q;
    logic crc_d;
    logic ts16_q;
    logic ts16_d;
    // Partial insert state
    logic partial_q;
    logic partial_d;
    logic [`RATE_N_W-1:0] rate_q;
    logic [`RATE_N_W-1:0] rate_d;
    logic rate_err_q;
    logic rate_err_d;
    logic [TS_W-1:0] slot_en_q;
    logic [TS_W-1:0] slot_en_d;
    logic bearer_fail;

    // Rate multiple check shared by acceptance and error flag
    function automatic logic rate_ok(input logic [`RATE_N_W-1:0] n);
        rate_ok = (n >= `RATE_N_MIN) && (n <= `RATE_N_MAX);
    endfunction

    // Mask selected channels to the first n of the satellite stream
    function automatic logic [TS_W-1:0] first_n_mask(input logic [`RATE_N_W-1:0] n);
        first_n_mask = '0;
        for (int i = 0; i < TS_W; i++) begin
            if (i < int'(n)) begin
                first_n_mask[i] = 1'b1;
            end
        end
    endfunction

    // Backup bearer clock; transmit is the clock that failed, so it falls to internal
    function automatic logic [`CLK_SEL_W-1:0] backup_clk(input logic [`CLK_SEL_W-1:0] sel);
        if (sel == `CLK_TRANSMIT) begin
            backup_clk = `CLK_INTERNAL;
        end else begin
            backup_clk = sel;
        end
    endfunction

    // Alarm mapping lives in its own module
    alarm_map #(
        .CHANNELS(CHANNELS)
    ) u_alarm_map (
        .mclk(mclk),
        .reset(reset),
        .map_sel(map_sel),
        .ext_alarm_n(ext_alarm_n),
        .rx_fail(rx_fail),
        .alarm_ok(alarm_ok)
    );

    // Receive configuration: follow overrides software writes of tracked set
    // Write strobes are single-cycle; one held high rewrites on every edge
    always_comb begin
        tracked_d = tracked_q;
        ts_d = ts_q;
        local_d = local_q;
        if (follow_tx) begin
            tracked_d = tx_tracked_cfg;
        end else if (rx_tracked_we) begin
            tracked_d = rx_tracked_wr;
        end
        // Timeslots, buffer, clocking, IF and sweep are never touched by follow
        if (rx_insert_ts_we && drop_insert) begin
            ts_d = rx_insert_ts_wr;
        end
        if (rx_local_we) begin
            local_d = rx_local_wr;
        end
    end

    // Receive configuration registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            tracked_q <= `TRACK_RESET;
            ts_q <= `TS_RESET;
            local_q <= `LOCAL_RESET;
        end else begin
            tracked_q <= tracked_d;
            ts_q <= ts_d;
            local_q <= local_d;
        end
    end

    // Bearer status comes from the line side, so it is synchronised first
    // Only the second stage feeds logic; the first may still be settling
    always_ff @(posedge mclk) begin
        if (reset) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            ais_meta_q <= 1'b0;
            ais_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= bearer_clk_lost;
            clk_sync_q <= clk_meta_q;
            ais_meta_q <= bearer_ais;
            ais_sync_q <= ais_meta_q;
        end
    end

    // Either fault sends a looped bearer to backup
    assign bearer_fail = clk_sync_q | ais_sync_q;

    // Routing state; backup is left as soon as the looped bearer recovers
    // Generate mode wins over any fault, since a generated bearer needs no input
    always_comb begin
        state_d = state_q;
        case (state_q)
            BEARER_LOOPED: begin
                if (generate_mode) begin
                    state_d = BEARER_GENERATED;
                end else if (bearer_fail) begin
                    state_d = BEARER_BACKUP;
                end
            end
            BEARER_BACKUP: begin
                if (generate_mode) begin
                    state_d = BEARER_GENERATED;
                end else if (!bearer_fail) begin
                    state_d = BEARER_LOOPED;
                end
            end
            BEARER_GENERATED: begin
                if (!generate_mode) begin
                    state_d = bearer_fail ? BEARER_BACKUP : BEARER_LOOPED;
                end
            end
            default: state_d = BEARER_LOOPED;
        endcase
    end

    // Generator controls follow the next state so outputs match it
    always_comb begin
        use_gen_d = (state_d != BEARER_LOOPED);
        clk_sel_d = `CLK_TRANSMIT;
        case (state_d)
            BEARER_GENERATED: clk_sel_d = gen_clk_sel;
            BEARER_BACKUP: clk_sel_d = backup_clk(backup_clk_sel);
            default: clk_sel_d = `CLK_TRANSMIT;
        endcase
        mf_d = use_gen_d & fmt_multiframe;
        crc_d = use_gen_d & fmt_crc;
        ts16_d = use_gen_d & fmt_multiframe & cas_mode;
    end

    // Routing and generator registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= BEARER_LOOPED;
            use_gen_q <= 1'b0;
            clk_sel_q <= `CLK_TRANSMIT;
            mf_q <= 1'b0;
            crc_q <= 1'b0;
            ts16_q <= 1'b0;
        end else begin
            state_q <= state_d;
            use_gen_q <= use_gen_d;
            clk_sel_q <= clk_sel_d;
            mf_q <= mf_d;
            crc_q <= crc_d;
            ts16_q <= ts16_d;
        end
    end

    // Partial insert: blocked while following; bad rate keeps last good one
    // Keeping the last good multiple stops the slot mask widening past the carrier
    always_comb begin
        partial_d = partial_req & ~follow_tx & drop_insert;
        rate_d = rate_q;
        rate_err_d = partial_d & ~rate_ok(sat_rate_n);
        if (partial_d && rate_ok(sat_rate_n)) begin
            rate_d = sat_rate_n;
        end
        if (partial_d) begin
            slot_en_d = rx_slot_strobe & sat_ts_select & first_n_mask(rate_d);
        end else begin
            slot_en_d = rx_slot_strobe;
        end
    end

    // Partial insert registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            partial_q <= 1'b0;
            rate_q <= `RATE_N_RESET;
            rate_err_q <= 1'b0;
            slot_en_q <= '0;
        end else begin
            partial_q <= partial_d;
            rate_q <= rate_d;
            rate_err_q <= rate_err_d;
            slot_en_q <= slot_en_d;
        end
    end

    // All outputs straight from flip-flops; receive configuration first
    assign rx_tracked_cfg = tracked_q;
    assign rx_insert_ts = ts_q;
    assign rx_local_cfg = local_q;

    // Routing and generator controls
    assign bearer_state = state_q;
    assign use_generated = use_gen_q;
    assign bearer_clk_sel = clk_sel_q;
    assign gen_multiframe = mf_q;
    assign gen_crc = crc_q;
    assign gen_ts16_mf = ts16_q;

    // Partial insert
    assign partial_active = partial_q;
    assign total_rate_n = rate_q;
    assign rate_n_error = rate_err_q;
    assign insert_slot_en = slot_en_q;
endmodule // alarm_bearer_select

// file: design/alarm_map.sv
/*
 * Backward alarm mapper: synchronises external alarm pins and maps them,
 * the receive-fail summary, or OK onto four registered alarm outputs.
 * Assumes the pins are asynchronous and the fail summary is on mclk.
 */
`timescale 1ns/100ps
`include "alarm_bearer_consts.svh"
module alarm_map
    import alarm_bearer_pkg::*;
#(
    parameter int CHANNELS = `ALARM_CHANNELS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Selection and sources
    input wire logic [`MAP_SEL_W-1:0] map_sel,
    input wire logic [CHANNELS-1:0] ext_alarm_n,
    input wire logic rx_fail,
    // Mapped alarms, high means OK
    output logic [CHANNELS-1:0] alarm_ok
);
    logic [CHANNELS-1:0] meta_q;
    logic [CHANNELS-1:0] sync_q;
    logic [CHANNELS-1:0] alarm_ok_d;
    logic [CHANNELS-1:0] alarm_ok_q;

    // Per-channel source choice: 0 external, 1 internal, 2 OK
    function automatic logic pick(input logic [1:0] src, input logic ext, input logic fail);
        case (src)
            2'h0: pick = ext;
            2'h1: pick = ~fail;
            default: pick = `ALARM_OK;
        endcase
    endfunction

    // Mapping is combinational off the selection so a change shows next edge
    always_comb begin
        alarm_ok_d = {CHANNELS{`ALARM_OK}};
        for (int i = 0; i < CHANNELS; i++) begin
            case (map_sel)
                `MAP_ALL_EXTERNAL: alarm_ok_d[i] = pick(2'h0, sync_q[i], rx_fail);
                `MAP_FIRST_INT_REST_EXT: alarm_ok_d[i] = pick((i == 0) ? 2'h1 : 2'h0, sync_q[i], rx_fail);
                `MAP_FIRST_INT_REST_OK: alarm_ok_d[i] = pick((i == 0) ? 2'h1 : 2'h2, sync_q[i], rx_fail);
                `MAP_ALL_INTERNAL: alarm_ok_d[i] = pick(2'h1, sync_q[i], rx_fail);
                default: alarm_ok_d[i] = `ALARM_OK;
            endcase
        end
    end

    // Two-stage synchroniser; open pin reads high, hence OK after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_q <= {CHANNELS{`ALARM_OK}};
            sync_q <= {CHANNELS{`ALARM_OK}};
            alarm_ok_q <= {CHANNELS{`ALARM_OK}};
        end else begin
            meta_q <= ext_alarm_n;
            sync_q <= meta_q;
            alarm_ok_q <= alarm_ok_d;
        end
    end

    assign alarm_ok = alarm_ok_q;
endmodule // alarm_map

// file: sim/alarm_bearer_properties.sv
/*
 * Concurrent checks on the ports of the alarm and bearer select top.
 * Assumes binding to that top, one clock mclk and synchronous reset.
 */
`timescale 1ns/100ps
module alarm_bearer_properties #(
    parameter int CHANNELS = 4,
    parameter int TRACK_W = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Alarm path
    input wire logic [2:0] map_sel,
    input wire logic rx_fail,
    input wire logic [CHANNELS-1:0] alarm_ok,
    // Follow and config
    input wire logic follow_tx,
    input wire logic [TRACK_W-1:0] tx_tracked_cfg,
    input wire logic rx_tracked_we,
    input wire logic [TRACK_W-1:0] rx_tracked_cfg,
    // Bearer and partial insert
    input wire logic generate_mode,
    input wire logic bearer_clk_lost,
    input wire logic bearer_ais,
    input wire logic cas_mode,
    input wire logic [1:0] bearer_state,
    input wire logic use_generated,
    input wire logic gen_ts16_mf,
    input wire logic partial_req,
    input wire logic drop_insert,
    input wire logic partial_active,
    input wire logic [5:0] total_rate_n
);
    // Everything lives in one domain, so clock and reset are set once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Alarm mapping, one edge after the cause
    AST_ALL_INT: assert property (map_sel == 3'h4 |=> alarm_ok == {CHANNELS{~$past(rx_fail)}})
        else $error("all-internal map wrong");
    AST_FIRST_OK: assert property (map_sel == 3'h3 |=> alarm_ok[0] == ~$past(rx_fail) && alarm_ok[3:1] == 3'h7)
        else $error("first-internal rest-OK map wrong");
    // Follow copies each edge and holds afterwards
    AST_TRACK: assert property (follow_tx |=> rx_tracked_cfg == $past(tx_tracked_cfg))
        else $error("tracked config not following");
    AST_HOLD: assert property (!follow_tx && !rx_tracked_we |=> $stable(rx_tracked_cfg))
        else $error("tracked config lost");
    AST_NO_PARTIAL: assert property (follow_tx |=> !partial_active)
        else $error("partial insert while following");
    AST_PARTIAL_ON: assert property (partial_req && drop_insert && !follow_tx |=> partial_active)
        else $error("partial insert not taken");
    // Bearer routing
    AST_GEN: assert property (generate_mode |=> bearer_state == 2'h2 && use_generated)
        else $error("generated routing not entered");
    AST_LOOP: assert property ((!generate_mode && !bearer_clk_lost && !bearer_ais) [*4] |=>
        bearer_state == 2'h0 && !use_generated)
        else $error("looped bearer not used");
    AST_BACKUP: assert property ((!generate_mode && (bearer_clk_lost || bearer_ais)) [*4] |=>
        bearer_state == 2'h1)
        else $error("backup bearer not used");
    AST_NO_TS16: assert property (!cas_mode |=> !gen_ts16_mf)
        else $error("signalling multiframe without signalling mode");
    AST_RATE: assert property (total_rate_n inside {[6'h02:6'h20]})
        else $error("total rate multiple out of range");

    // Main scenarios reached
    cover property (bearer_state == 2'h1);
    cover property (partial_active);
    cover property (follow_tx ##1 !follow_tx);
endmodule // alarm_bearer_properties

// file: sim/alarm_bearer_select_bench.sv
/*
 * Self-checking bench for the alarm and bearer select top.
 * Assumes the design, far-side model and checker are compiled first.
 */
`timescale 1ns/100ps
module alarm_bearer_select_bench;
    logic mclk, reset, rx_fail, follow_tx, rx_tracked_we, drop_insert, rx_insert_ts_we, rx_local_we;
    logic generate_mode, fmt_multiframe, fmt_crc, cas_mode, partial_req, lose_clk, send_ais;
    logic bearer_clk_lost, bearer_ais, use_generated, gen_multiframe, gen_crc, gen_ts16_mf;
    logic partial_active, rate_n_error, ok;
    logic [2:0] map_sel;
    logic [3:0] gnd, ext_alarm_n, alarm_ok;
    logic [1:0] gen_clk_sel, backup_clk_sel, bearer_state, bearer_clk_sel;
    logic [31:0] tx_tracked_cfg, rx_tracked_wr, rx_insert_ts_wr, sat_ts_select, rx_slot_strobe;
    logic [31:0] rx_tracked_cfg, rx_insert_ts, insert_slot_en, r, t, seed;
    logic [15:0] rx_local_wr, rx_local_cfg;
    logic [5:0] sat_rate_n, total_rate_n, exp_n;
    int num_errors, n_checks, cycles;

    alarm_bearer_select dut_u (
        .mclk, .reset, .map_sel, .ext_alarm_n, .rx_fail, .alarm_ok, .follow_tx, .tx_tracked_cfg,
        .rx_tracked_wr, .rx_tracked_we, .drop_insert, .rx_insert_ts_wr, .rx_insert_ts_we, .rx_local_wr,
        .rx_local_we, .rx_tracked_cfg, .rx_insert_ts, .rx_local_cfg, .generate_mode, .bearer_clk_lost,
        .bearer_ais, .gen_clk_sel, .backup_clk_sel, .fmt_multiframe, .fmt_crc, .cas_mode, .bearer_state,
        .use_generated, .bearer_clk_sel, .gen_multiframe, .gen_crc, .gen_ts16_mf, .partial_req,
        .sat_rate_n, .sat_ts_select, .rx_slot_strobe, .partial_active, .total_rate_n, .rate_n_error,
        .insert_slot_en);
    alarm_far_side far_u (.gnd, .lose_clk, .send_ais, .ext_alarm_n, .bearer_clk_lost, .bearer_ais);

    // Clock at 10 MHz
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected alarms, high meaning OK, from map, fail summary and pins
    function logic [3:0] exp_al(logic [2:0] m, logic f, logic [3:0] e);
        case (m)
            3'h1: return e;
            3'h2: return {e[3:1], ~f};
            3'h3: return {3'h7, ~f};
            3'h4: return {4{~f}};
            default: return 4'hF;
        endcase
    endfunction

    // Backup bearer clock: the failed transmit clock is never chosen
    function logic [1:0] exp_bk(logic [1:0] s);
        return (s == 2'h1) ? 2'h2 : s;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Fresh random levels on the data-like inputs
    task rand_in;
        r = rnd();
        {rx_fail, fmt_multiframe, fmt_crc, cas_mode, gnd} = r[7:0];
        tx_tracked_cfg = rnd();
        rx_tracked_wr = rnd();
        rx_insert_ts_wr = rnd();
        rx_local_wr = r[31:16];
        sat_ts_select = rnd();
        rx_slot_strobe = rnd();
    endtask

    task test_done;
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        seed = 32'h9189;
        {num_errors, n_checks, cycles} = '0;
        reset = 1'b1;
        {follow_tx, rx_tracked_we, drop_insert, rx_insert_ts_we, rx_local_we} = '0;
        {generate_mode, partial_req, lose_clk, send_ais} = '0;
        {map_sel, gen_clk_sel, backup_clk_sel} = 7'h08;
        sat_rate_n = 6'h02;
        exp_n = 6'h02;
        rand_in();
        cyc(5);
        reset = 1'b0;
        // Every mapping, then a lone map change seen one edge later
        for (int m = 0; m < 8; m++) begin
            repeat (4) begin
                map_sel = 3'(m);
                rand_in();
                cyc(4);
                check(alarm_ok, exp_al(map_sel, rx_fail, ext_alarm_n));
                map_sel = 3'(m + 1);
                cyc(1);
                check(alarm_ok, exp_al(map_sel, rx_fail, ext_alarm_n));
            end
        end
        // Brief follow with independent writes alongside
        {follow_tx, rx_local_we, drop_insert, rx_insert_ts_we, rx_tracked_we} = 5'h1F;
        cyc(1);
        check(rx_tracked_cfg, tx_tracked_cfg);
        {rx_local_we, rx_insert_ts_we, rx_tracked_we} = '0;
        t = rnd();
        tx_tracked_cfg = t;
        cyc(1);
        check(rx_tracked_cfg, t);
        follow_tx = 1'b0;
        tx_tracked_cfg = rnd();
        cyc(3);
        check(rx_tracked_cfg, t);
        check(rx_local_cfg, rx_local_wr);
        check(rx_insert_ts, rx_insert_ts_wr);
        // Software write lands with follow off; timeslot write refused outside drop/insert
        t = rx_insert_ts;
        rand_in();
        {drop_insert, rx_insert_ts_we, rx_tracked_we} = 3'b011;
        cyc(1);
        {drop_insert, rx_insert_ts_we, rx_tracked_we} = 3'b100;
        check(rx_tracked_cfg, rx_tracked_wr);
        check(rx_insert_ts, t);
        // Looped bearer, each fault kind with each backup clock, transmit included
        for (int k = 0; k < 8; k++) begin
            backup_clk_sel = 2'(k >> 1);
            {lose_clk, send_ais} = k[0] ? 2'b10 : 2'b01;
            cyc(4);
            check({bearer_state, use_generated, bearer_clk_sel}, {2'h1, 1'b1, exp_bk(backup_clk_sel)});
            {lose_clk, send_ais} = 2'b00;
            cyc(4);
            check({bearer_state, use_generated}, {2'h0, 1'b0});
        end
        // Generated bearer over every clock source and format
        generate_mode = 1'b1;
        for (int k = 0; k < 8; k++) begin
            gen_clk_sel = 2'(k);
            {fmt_multiframe, fmt_crc, cas_mode} = 3'(k);
            cyc(2);
            check({bearer_state, bearer_clk_sel}, {2'h2, gen_clk_sel});
            check({gen_multiframe, gen_crc, gen_ts16_mf}, {fmt_multiframe, fmt_crc, fmt_multiframe & cas_mode});
        end
        generate_mode = 1'b0;
        // Partial insert: rate boundaries first, random rates after
        {drop_insert, partial_req} = 2'b11;
        for (int k = 0; k < 16; k++) begin
            rand_in();
            r = rnd();
            sat_rate_n = (k < 4) ? 6'(24'h86_00_81 >> (6 * k)) : r[5:0]; // 1, 2, 32, 33 first
            ok = sat_rate_n inside {[6'h02:6'h20]};
            if (ok)
                exp_n = sat_rate_n;
            cyc(2);
            check({total_rate_n, rate_n_error, partial_active}, {exp_n, ~ok, 1'b1});
            check(insert_slot_en, rx_slot_strobe & sat_ts_select & 32'((33'h1 << exp_n) - 1));
        end
        follow_tx = 1'b1;
        cyc(2);
        check(partial_active, 1'b0);
        {follow_tx, partial_req} = 2'b00;
        cyc(2);
        check(insert_slot_en, rx_slot_strobe);
        test_done();
    end
endmodule // alarm_bearer_select_bench

bind alarm_bearer_select alarm_bearer_properties #(.CHANNELS(CHANNELS), .TRACK_W(TRACK_W)) props_u (
    .mclk, .reset, .map_sel, .rx_fail, .alarm_ok, .follow_tx, .tx_tracked_cfg, .rx_tracked_we,
    .rx_tracked_cfg, .generate_mode, .bearer_clk_lost, .bearer_ais, .cas_mode, .bearer_state,
    .use_generated, .gen_ts16_mf, .partial_req, .drop_insert, .partial_active, .total_rate_n);

// file: sim/alarm_far_side.sv
/*
 * Far-side model: alarm wiring with pull-ups and terrestrial bearer status.
 * Assumes the bench moves its commands away from the rising mclk edge.
 */
`timescale 1ns/100ps
module alarm_far_side (
    // Commands from the bench
    input wire logic [3:0] gnd,
    input wire logic lose_clk,
    input wire logic send_ais,
    // Pins into the block
    output logic [3:0] ext_alarm_n,
    output logic bearer_clk_lost,
    output logic bearer_ais
);
    // Open pins float high through the pull-up, grounding signals a fail
    assign ext_alarm_n = ~gnd;
    // Faults arrive late, as from equipment on an unrelated clock
    assign #3 bearer_clk_lost = lose_clk;
    assign #3 bearer_ais = send_ais;
endmodule // alarm_far_side
